// ### hdl/qfr_reg_decode.sv
// Register decode and storage of the four-quadrant framer processor port.
//
// Contract
// - Normal registers decoded only with address bit ten low
// - Address bits nine and eight select quadrant one to four
// - Device-wide registers exist once, in quadrant one
// - Every quadrant resets into T1 line mode
// - Backplane resets to serial clock and data
// - Interrupt enables and alarm transmission reset off
// - Writes to unused bits change nothing
// - Writable bits read back last written value
// - Reset clears writable bits to zero
// - Writes to read-only bits change nothing
// - Sub-block requests gathered onto one interrupt pin
`timescale 1ns/1ps
module qfr_reg_decode (
   // Clock, reset and enable
   input  wire logic        CLK,
   input  wire logic        SRST,
   input  wire logic        CE,
   // Processor bus pins
   input  wire logic        CS_N,
   input  wire logic        RD_N,
   input  wire logic        WR_N,
   input  wire logic [10:0] ADDR,
   input  wire logic [7:0]  DATA_IN,
   output logic      [7:0]  DATA_OUT,
   output logic             DATA_OE_N,
   // Interrupt requests from the sub-blocks, eight per quadrant
   input  wire logic [31:0] INT_REQ,
   // Device outputs
   output logic             INT_N,
   output logic      [3:0]  E1_MODE,
   output logic             SW_RESET,
   output logic             PMON_UPDATE,
   output logic             TEST_SEL
);

   localparam int unsigned AW = qfr_pkg::ADDR_W;
   localparam int unsigned DW = qfr_pkg::DATA_W;
   localparam int unsigned NQ = qfr_pkg::NUM_QUAD;
   localparam int unsigned NR = qfr_pkg::NUM_REG;
   localparam int unsigned XW = qfr_pkg::IDX_W;

   typedef enum logic [1:0] {
      QFR_IDLE  = 2'b00,
      QFR_READ  = 2'b01,
      QFR_WRITE = 2'b10
   } qfr_bus_state_t;

   // Filtered bus pins
   logic [2:0]    strb_f;
   logic          cs_n_f;
   logic          rd_n_f;
   logic          wr_n_f;
   logic [AW-1:0] addr_f;
   logic [DW-1:0] din_f;
   logic [NQ*8-1:0] req_f;

   qfr_pin_sync #(
      .W (3)
   ) u_strb_sync (
      .clk       (CLK),
      .srst      (SRST),
      .ce        (CE),
      .pin_in    ({CS_N, RD_N, WR_N}),
      .rst_val   (3'h7),
      .level_out (strb_f)
   );

   qfr_pin_sync #(
      .W (AW + DW)
   ) u_data_sync (
      .clk       (CLK),
      .srst      (SRST),
      .ce        (CE),
      .pin_in    ({ADDR, DATA_IN}),
      .rst_val   ({(AW + DW){1'b0}}),
      .level_out ({addr_f, din_f})
   );

   qfr_pin_sync #(
      .W (NQ * 8)
   ) u_req_sync (
      .clk       (CLK),
      .srst      (SRST),
      .ce        (CE),
      .pin_in    (INT_REQ),
      .rst_val   ({(NQ * 8){1'b0}}),
      .level_out (req_f)
   );

   assign cs_n_f = strb_f[2];
   assign rd_n_f = strb_f[1];
   assign wr_n_f = strb_f[0];

   // Address decode
   logic            test_sp;
   logic [1:0]      quad;
   logic [7:0]      ofs;
   logic [XW-1:0]   idx;
   logic            hit;
   logic            global_only;
   logic [DW-1:0]   wmask;

   assign test_sp = addr_f[qfr_pkg::TEST_SEL_BIT];
   assign quad    = addr_f[qfr_pkg::QUAD_MSB:qfr_pkg::QUAD_LSB];
   assign ofs     = addr_f[qfr_pkg::OFS_MSB:0];

   always_comb begin
      idx   = '0;
      hit   = 1'b0;
      wmask = qfr_pkg::MASK_RO;
      for (int i = 0; i < NR; i++) begin
         if (qfr_pkg::REG_OFS[i] == ofs) begin
            idx = XW'(i);
            hit = 1'b1;
            case (qfr_pkg::REG_ACC[i])
               qfr_pkg::QFR_ACC_RW:    wmask = qfr_pkg::MASK_RW;
               qfr_pkg::QFR_ACC_MIXED: wmask = qfr_pkg::MASK_MIXED;
               default:                wmask = qfr_pkg::MASK_RO;
            endcase
         end
      end
      // The revision byte is all status; a write there only pulses the update
      if (ofs == qfr_pkg::OFS_REV_ID) begin
         wmask = qfr_pkg::MASK_RO;
      end
   end

   // Master test and software reset exist only in the first window
   assign global_only = (ofs == qfr_pkg::OFS_MASTER_TEST) ||
                        (ofs == qfr_pkg::OFS_SW_RESET);

   logic normal_hit;
   assign normal_hit = !test_sp && hit &&
                       (!global_only || quad == qfr_pkg::QUAD_ONE);

   // Bus cycle tracking: a write commits at the end of its strobe
   qfr_bus_state_t state_r;
   qfr_bus_state_t state_nxt;
   logic           wr_commit;

   always_comb begin
      state_nxt = state_r;
      wr_commit = 1'b0;
      case (state_r)
         QFR_IDLE: begin
            if (!cs_n_f && !wr_n_f) begin
               state_nxt = QFR_WRITE;
            end else if (!cs_n_f && !rd_n_f) begin
               state_nxt = QFR_READ;
            end
         end
         QFR_READ: begin
            if (cs_n_f || rd_n_f) begin
               state_nxt = QFR_IDLE;
            end
         end
         QFR_WRITE: begin
            if (cs_n_f || wr_n_f) begin
               state_nxt = QFR_IDLE;
               wr_commit = 1'b1;
            end
         end
         default: state_nxt = QFR_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_r <= QFR_IDLE;
      end else if (CE) begin
         state_r <= state_nxt;
      end
   end

   // Write data and address latched while the strobe is active
   logic [AW-1:0] wr_addr_r;
   logic [DW-1:0] wr_data_r;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         wr_addr_r <= '0;
         wr_data_r <= '0;
      end else if (CE && state_nxt == QFR_WRITE) begin
         wr_addr_r <= addr_f;
         wr_data_r <= din_f;
      end
   end

   // Decode of the latched write address
   logic [1:0]    w_quad;
   logic [7:0]    w_ofs;
   logic [XW-1:0] w_idx;
   logic          w_hit;
   logic [DW-1:0] w_mask;

   assign w_quad = wr_addr_r[qfr_pkg::QUAD_MSB:qfr_pkg::QUAD_LSB];
   assign w_ofs  = wr_addr_r[qfr_pkg::OFS_MSB:0];

   always_comb begin
      w_idx  = '0;
      w_hit  = 1'b0;
      w_mask = qfr_pkg::MASK_RO;
      for (int i = 0; i < NR; i++) begin
         if (qfr_pkg::REG_OFS[i] == w_ofs) begin
            w_idx = XW'(i);
            w_hit = 1'b1;
            case (qfr_pkg::REG_ACC[i])
               qfr_pkg::QFR_ACC_RW:    w_mask = qfr_pkg::MASK_RW;
               qfr_pkg::QFR_ACC_MIXED: w_mask = qfr_pkg::MASK_MIXED;
               default:                w_mask = qfr_pkg::MASK_RO;
            endcase
         end
      end
      if (wr_addr_r[qfr_pkg::TEST_SEL_BIT]) begin
         w_hit = 1'b0;
      end
      if (((w_ofs == qfr_pkg::OFS_MASTER_TEST) || (w_ofs == qfr_pkg::OFS_SW_RESET)) &&
          (w_quad != qfr_pkg::QUAD_ONE)) begin
         w_hit = 1'b0;
      end
      if (w_ofs == qfr_pkg::OFS_REV_ID) begin
         w_mask = qfr_pkg::MASK_RO;
      end
   end

   // Register storage, one bank per quadrant
   logic [DW-1:0] mem_r [0:NQ-1][0:NR-1];

   genvar q;
   generate
      for (q = 0; q < NQ; q++) begin : g_quad
         always_ff @(posedge CLK) begin
            if (SRST) begin
               for (int i = 0; i < NR; i++) begin
                  mem_r[q][i] <= qfr_pkg::RESET_VAL;
               end
            end else if (CE && wr_commit && w_hit && w_quad == 2'(q)) begin
               // Only writable bits take the new value
               mem_r[q][w_idx] <= (wr_data_r & w_mask) |
                                  (mem_r[q][w_idx] & ~w_mask);
            end
         end
      end
   endgenerate

   // Read value: stored bits plus live status in read-only positions
   logic [DW-1:0] rd_val;
   logic [DW-1:0] live;

   always_comb begin
      live = req_f[quad * 8 +: 8];
      if (ofs == qfr_pkg::OFS_REV_ID) begin
         live = {qfr_pkg::REVISION_CODE, 2'b00, quad};
      end
      if (normal_hit) begin
         rd_val = (mem_r[quad][idx] & wmask) | (live & ~wmask);
      end else begin
         rd_val = '0;
      end
   end

   // Data bus drive: enabled only during a selected read
   always_ff @(posedge CLK) begin
      if (SRST) begin
         DATA_OUT  <= '0;
         DATA_OE_N <= 1'b1;
      end else if (CE) begin
         DATA_OUT  <= rd_val;
         DATA_OE_N <= !(state_nxt == QFR_READ);
      end
   end

   // Interrupt aggregation: any sub-block request pulls the pin low
   always_ff @(posedge CLK) begin
      if (SRST) begin
         INT_N <= 1'b1;
      end else if (CE) begin
         INT_N <= ~|req_f;
      end
   end

   // Register table positions of the device-wide and per-quadrant controls
   logic [XW-1:0] rst_idx;
   logic [XW-1:0] rev_idx;
   logic [XW-1:0] cfg_idx;

   // Per-quadrant line mode, T1 after reset
   genvar m;
   generate
      for (m = 0; m < NQ; m++) begin : g_mode
         always_ff @(posedge CLK) begin
            if (SRST) begin
               E1_MODE[m] <= 1'b0;
            end else if (CE) begin
               E1_MODE[m] <= mem_r[m][cfg_idx][qfr_pkg::BIT_E1_T1_SEL];
            end
         end
      end
   endgenerate

   // Device-wide software reset, single instance
   always_comb begin
      rst_idx = '0;
      rev_idx = '0;
      cfg_idx = '0;
      for (int i = 0; i < NR; i++) begin
         if (qfr_pkg::REG_OFS[i] == qfr_pkg::OFS_GLOBAL_CFG) begin
            cfg_idx = XW'(i);
         end
         if (qfr_pkg::REG_OFS[i] == qfr_pkg::OFS_SW_RESET) begin
            rst_idx = XW'(i);
         end
         if (qfr_pkg::REG_OFS[i] == qfr_pkg::OFS_REV_ID) begin
            rev_idx = XW'(i);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         SW_RESET <= 1'b0;
      end else if (CE) begin
         SW_RESET <= mem_r[0][rst_idx][qfr_pkg::BIT_SW_RESET];
      end
   end

   // A write to the revision register latches the counters of all quadrants
   always_ff @(posedge CLK) begin
      if (SRST) begin
         PMON_UPDATE <= 1'b0;
      end else if (CE) begin
         PMON_UPDATE <= wr_commit && w_hit && (w_idx == rev_idx);
      end
   end

   // Test space select follows the address of the current access
   always_ff @(posedge CLK) begin
      if (SRST) begin
         TEST_SEL <= 1'b0;
      end else if (CE) begin
         TEST_SEL <= test_sp && (state_nxt != QFR_IDLE);
      end
   end

endmodule

// ### hdl/qfr_pkg.sv
// Constants and register map of the quad framer register decode block.
package qfr_pkg;

   // Processor bus geometry
   localparam int unsigned ADDR_W   = 11;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned NUM_QUAD = 4;
   localparam int unsigned NUM_REG  = 48;
   localparam int unsigned IDX_W    = 6;

   // Address fields
   localparam int unsigned TEST_SEL_BIT = 10;
   localparam int unsigned QUAD_LSB     = 8;
   localparam int unsigned QUAD_MSB     = 9;
   localparam int unsigned OFS_MSB      = 7;

   localparam logic [7:0] RESET_VAL  = 8'h00;
   localparam logic [7:0] MASK_RW    = 8'hFF;
   localparam logic [7:0] MASK_MIXED = 8'h0F;
   localparam logic [7:0] MASK_RO    = 8'h00;
   localparam logic [1:0] QUAD_ONE   = 2'h0;

   // Offsets with behaviour beyond storage
   localparam logic [7:0] OFS_GLOBAL_CFG  = 8'h00;
   localparam logic [7:0] OFS_INT_SRC1    = 8'h07;
   localparam logic [7:0] OFS_INT_SRC3    = 8'h09;
   localparam logic [7:0] OFS_MASTER_TEST = 8'h0B;
   localparam logic [7:0] OFS_REV_ID      = 8'h0D;
   localparam logic [7:0] OFS_SW_RESET    = 8'h0E;

   // Field positions
   localparam int unsigned BIT_E1_T1_SEL = 0;
   localparam int unsigned BIT_SW_RESET  = 0;
   localparam int unsigned REV_LSB       = 4;

   // Arbitrary neutral revision code
   localparam logic [3:0] REVISION_CODE = 4'h1;

   typedef enum logic [1:0] {
      QFR_ACC_RW    = 2'b00,
      QFR_ACC_RO    = 2'b01,
      QFR_ACC_MIXED = 2'b10
   } qfr_access_t;

   // Register table: offset within a quadrant window and access kind
   localparam logic [7:0] REG_OFS [0:NUM_REG-1] = '{
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h10,
      8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
      8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21,
      8'h28, 8'h29, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h38,
      8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h48, 8'h49
   };

   localparam qfr_access_t REG_ACC [0:NUM_REG-1] = '{
      QFR_ACC_RW,    QFR_ACC_MIXED, QFR_ACC_RW,    QFR_ACC_RW,
      QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RO,
      QFR_ACC_RO,    QFR_ACC_RO,    QFR_ACC_RW,    QFR_ACC_RW,
      QFR_ACC_MIXED, QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,
      QFR_ACC_RW,    QFR_ACC_MIXED, QFR_ACC_RW,    QFR_ACC_MIXED,
      QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_MIXED,
      QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,
      QFR_ACC_MIXED, QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_MIXED,
      QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,
      QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,
      QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_MIXED,
      QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW,    QFR_ACC_RW
   };

endpackage

// ### hdl/qfr_pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement filter.
`timescale 1ns/1ps
module qfr_pin_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   // Pin side
   input  wire logic [W-1:0] pin_in,
   input  wire logic [W-1:0] rst_val,
   // Filtered level
   output logic      [W-1:0] level_out
);

   logic [W-1:0] meta_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_bit
         always_ff @(posedge clk) begin
            if (srst) begin
               // Stages start at the idle level so no false edge follows reset
               meta_r[b]    <= rst_val[b];
               s2_r[b]      <= rst_val[b];
               s3_r[b]      <= rst_val[b];
               level_out[b] <= rst_val[b];
            end else if (ce) begin
               meta_r[b] <= pin_in[b];
               s2_r[b]   <= meta_r[b];
               s3_r[b]   <= s2_r[b];
               // A change counts only once stages two and three agree
               if (s2_r[b] == s3_r[b]) begin
                  level_out[b] <= s3_r[b];
               end
            end
         end
      end
   endgenerate

endmodule

// ### verification/qfr_reg_decode_sva.sv
// Concurrent checks on the ports of the register decode block.
`timescale 1ns/1ps
module qfr_reg_decode_chk (
   // Clock and control
   input wire logic        CLK,
   input wire logic        SRST,
   input wire logic        CE,
   // Processor bus
   input wire logic        CS_N,
   input wire logic        RD_N,
   input wire logic        WR_N,
   input wire logic [10:0] ADDR,
   input wire logic [7:0]  DATA_IN,
   input wire logic [7:0]  DATA_OUT,
   input wire logic        DATA_OE_N,
   // Interrupts and device outputs
   input wire logic [31:0] INT_REQ,
   input wire logic        INT_N,
   input wire logic [3:0]  E1_MODE,
   input wire logic        SW_RESET,
   input wire logic        PMON_UPDATE,
   input wire logic        TEST_SEL
);
   logic [3:0] quiet_cnt_r;

   // Cycles since the write strobe was last seen low
   always_ff @(posedge CLK) begin
      if (SRST || (!CS_N && !WR_N)) begin
         quiet_cnt_r <= 4'h0;
      end else if (CE && quiet_cnt_r != 4'hF) begin
         quiet_cnt_r <= quiet_cnt_r + 4'h1;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   a_reset_outputs: assert property (
      $fell(SRST) |-> DATA_OE_N && INT_N && E1_MODE == 4'h0 && !SW_RESET
                      && !PMON_UPDATE && !TEST_SEL)
      else $error("outputs not at reset values");
   a_int_raise: assert property (
      (CE && INT_REQ != 32'h0)[*7] |-> !INT_N)
      else $error("interrupt not raised");
   a_int_drop: assert property (
      (CE && INT_REQ == 32'h0)[*7] |-> INT_N)
      else $error("interrupt not released");
   a_cfg_hold: assert property (
      quiet_cnt_r >= 4'hA |-> $stable(E1_MODE) && $stable(SW_RESET))
      else $error("configuration changed without a write");
   a_pmon_cause: assert property (
      PMON_UPDATE |-> quiet_cnt_r < 4'hA)
      else $error("update pulse without a write");
   a_pmon_single: assert property (
      PMON_UPDATE |=> !PMON_UPDATE)
      else $error("update pulse longer than one cycle");
   a_oe_on_read: assert property (
      $fell(DATA_OE_N) |-> !CS_N && !RD_N)
      else $error("data driven without a read");
   a_oe_release: assert property (
      (CE && (CS_N || RD_N))[*7] |-> DATA_OE_N)
      else $error("data still driven after read");
   a_test_zero: assert property (
      TEST_SEL && !DATA_OE_N |-> DATA_OUT == 8'h00)
      else $error("test space read not zero");
   a_test_cause: assert property (
      $rose(TEST_SEL) |-> ADDR[10])
      else $error("test select without address bit ten");
endmodule

bind qfr_reg_decode qfr_reg_decode_chk qfr_reg_decode_chk_i (
   .CLK(CLK), .SRST(SRST), .CE(CE), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
   .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
   .INT_REQ(INT_REQ), .INT_N(INT_N), .E1_MODE(E1_MODE), .SW_RESET(SW_RESET),
   .PMON_UPDATE(PMON_UPDATE), .TEST_SEL(TEST_SEL));

// ### verification/qfr_cpu_model.sv
// Processor model that drives the parallel register bus.
`timescale 1ns/1ps
module qfr_cpu_model (
   // Clock
   input  wire logic        clk,
   // Bus pins
   output logic             cs_n,
   output logic             rd_n,
   output logic             wr_n,
   output logic      [10:0] addr,
   output logic      [7:0]  data_in,
   input  wire logic [7:0]  data_out,
   input  wire logic        data_oe_n
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 11'h7FF;
      data_in = 8'hFF;
   end

   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      data_in = d;
      @(negedge clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (8) @(negedge clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
      repeat (8) @(negedge clk);
      // Released lines must not keep their last value
      addr = ~a;
      data_in = ~d;
   endtask

   task automatic rd(input logic [10:0] a, input logic [7:0] m, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (8) @(negedge clk);
      d = (data_oe_n === 1'b0) ? (data_out & m) : 8'hXX;
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (8) @(negedge clk);
      addr = ~a;
   endtask
endmodule

// ### verification/qfr_reg_decode_tb.sv
// Self-checking testbench of the register decode block.
`timescale 1ns/1ps
module qfr_reg_decode_tb;
   logic        clk;
   logic        srst;
   logic        ce = 1'b1;
   logic        cs_n;
   logic        rd_n;
   logic        wr_n;
   logic [10:0] addr;
   logic [7:0]  data_in;
   logic [7:0]  data_out;
   logic        data_oe_n;
   logic [31:0] int_req;
   logic        int_n;
   logic [3:0]  e1_mode;
   logic        sw_reset;
   logic        pmon_update;
   logic        test_sel;
   logic [7:0]  got;
   logic        test_seen = 1'b0;
   int          pmon_cnt = 0;
   int          mismatches = 0;
   int          checked = 0;

   qfr_reg_decode qfr_reg_decode_i (.CLK(clk), .SRST(srst), .CE(ce), .CS_N(cs_n),
      .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr), .DATA_IN(data_in), .DATA_OUT(data_out),
      .DATA_OE_N(data_oe_n), .INT_REQ(int_req), .INT_N(int_n), .E1_MODE(e1_mode),
      .SW_RESET(sw_reset), .PMON_UPDATE(pmon_update), .TEST_SEL(test_sel));
   qfr_cpu_model qfr_cpu_model_i (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (pmon_update === 1'b1) pmon_cnt <= pmon_cnt + 1;
      if (test_sel === 1'b1) test_seen <= 1'b1;
   end

   task automatic check(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic stop_test;
      $display("Counts: checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] pat(int q, int i);
      return 8'h5A + 8'(i * 7) + 8'(q * 49);
   endfunction

   function automatic logic [10:0] aq(int q, int i);
      return {1'b0, 2'(q), qfr_pkg::REG_OFS[i]};
   endfunction

   // Expected read value from access kind, stored byte and live status
   function automatic logic [7:0] expv(int q, int i, logic [7:0] wv);
      logic [7:0] m;
      logic [7:0] o;
      o = qfr_pkg::REG_OFS[i];
      m = (qfr_pkg::REG_ACC[i] == qfr_pkg::QFR_ACC_RW) ? qfr_pkg::MASK_RW :
          (qfr_pkg::REG_ACC[i] == qfr_pkg::QFR_ACC_MIXED) ? qfr_pkg::MASK_MIXED :
          qfr_pkg::MASK_RO;
      if (o == qfr_pkg::OFS_REV_ID) return {qfr_pkg::REVISION_CODE, 2'b00, 2'(q)};
      if (q != 0 && (o == qfr_pkg::OFS_MASTER_TEST || o == qfr_pkg::OFS_SW_RESET))
         return 8'h00;
      return (wv & m) | (int_req[q*8 +: 8] & ~m);
   endfunction

   task automatic do_reset;
      @(negedge clk);
      srst = 1'b1;
      repeat (4) @(negedge clk);
      srst = 1'b0;
   endtask

   task automatic t_defaults;
      for (int q = 0; q < 4; q++) begin
         for (int i = 0; i < qfr_pkg::NUM_REG; i++) begin
            qfr_cpu_model_i.rd(aq(q, i), 8'hFF, got);
            check(got, expv(q, i, 8'h00));
         end
      end
      check({4'h0, e1_mode}, 8'h00);
      check({7'h00, int_n}, 8'h01);
      check({7'h00, sw_reset}, 8'h00);
      $display("defaults test done");
   endtask

   task automatic t_readback;
      logic [7:0] g0;
      logic [7:0] g1;
      logic [7:0] g2;
      logic [7:0] g3;
      logic [7:0] sr;
      for (int q = 0; q < 4; q++) begin
         for (int i = 0; i < qfr_pkg::NUM_REG; i++) begin
            qfr_cpu_model_i.wr(aq(q, i), pat(q, i));
         end
      end
      for (int q = 0; q < 4; q++) begin
         for (int i = 0; i < qfr_pkg::NUM_REG; i++) begin
            qfr_cpu_model_i.rd(aq(q, i), 8'hFF, got);
            check(got, expv(q, i, pat(q, i)));
         end
      end
      g0 = pat(0, 0);
      g1 = pat(1, 0);
      g2 = pat(2, 0);
      g3 = pat(3, 0);
      sr = pat(0, 13);
      check({4'h0, g3[0], g2[0], g1[0], g0[0]}, {4'h0, e1_mode});
      check({7'h00, sw_reset}, {7'h00, sr[0]});
      check(8'(pmon_cnt), 8'h04);
      $display("readback test done");
   endtask

   task automatic t_test_space;
      qfr_cpu_model_i.wr(11'h402, ~pat(0, 2));
      qfr_cpu_model_i.wr(11'h00C, 8'hFF);
      qfr_cpu_model_i.rd(11'h002, 8'hFF, got);
      check(got, pat(0, 2));
      qfr_cpu_model_i.rd(11'h402, 8'hFF, got);
      check(got, 8'h00);
      qfr_cpu_model_i.rd(11'h00C, 8'hFF, got);
      check(got, 8'h00);
      check({7'h00, test_seen}, 8'h01);
      $display("test space test done");
   endtask

   task automatic t_interrupt;
      @(negedge clk);
      int_req = 32'h9600_5000;
      repeat (8) @(negedge clk);
      check({7'h00, int_n}, 8'h00);
      qfr_cpu_model_i.rd(11'h107, 8'hFF, got);
      check(got, expv(1, 7, 8'h00));
      qfr_cpu_model_i.rd(11'h301, 8'hFF, got);
      check(got, expv(3, 1, pat(3, 1)));
      int_req = 32'h0;
      repeat (8) @(negedge clk);
      check({7'h00, int_n}, 8'h01);
      $display("interrupt test done");
   endtask

   // With the clock enable low neither a write nor a request may take effect
   task automatic t_freeze;
      @(negedge clk);
      ce = 1'b0;
      int_req = 32'h0000_00FF;
      qfr_cpu_model_i.wr(11'h000, ~pat(0, 0));
      check({7'h00, int_n}, 8'h01);
      check({4'h0, e1_mode}, 8'h0A);
      int_req = 32'h0;
      ce = 1'b1;
      repeat (8) @(negedge clk);
      qfr_cpu_model_i.rd(11'h000, 8'hFF, got);
      check(got, expv(0, 0, pat(0, 0)));
      $display("freeze test done");
   endtask

   initial begin
      srst = 1'b1;
      int_req = 32'h0;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      t_defaults;
      t_readback;
      t_test_space;
      t_interrupt;
      t_freeze;
      do_reset;
      t_defaults;
      stop_test;
   end

   initial begin
      #2_000_000;
      mismatches++;
      stop_test;
   end
endmodule
